/* pkg/prot_cmd_pkg.sv */
// constants and types for the otp and sector protection command block
// assumes a single spi slave sampled by the block clock
package prot_cmd_pkg;

    // command opcodes
    localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06;
    localparam logic [7:0] OP_OTP_WRITE     = 8'h42;
    localparam logic [7:0] OP_OTP_READ      = 8'h4B;
    localparam logic [7:0] OP_CFG_READ      = 8'h2B;
    localparam logic [7:0] OP_CFG_PROGRAM   = 8'h2F;
    localparam logic [7:0] OP_VOL_READ      = 8'hE0;
    localparam logic [7:0] OP_VOL_WRITE     = 8'hE1;
    localparam logic [7:0] OP_PERS_READ     = 8'hE2;
    localparam logic [7:0] OP_PERS_PROGRAM  = 8'hE3;
    localparam logic [7:0] OP_PERS_ERASE    = 8'hE4;
    localparam logic [7:0] OP_ERASE_SUSPEND = 8'h75;

    // frame bit counts (rising sck edges since cs fell)
    localparam logic [6:0] BITS_OPCODE   = 7'h08;
    localparam logic [6:0] BITS_CFG_DATA = 7'h18;
    localparam logic [6:0] BITS_ADDR     = 7'h28;
    localparam logic [6:0] BITS_DUMMY    = 7'h30;
    localparam logic [6:0] BITS_SAT      = 7'h7F;

    // address layout
    localparam int OTP_AW      = 11;
    localparam int OTP_BYTES   = 2048;
    localparam int OTP_HI_MSB  = 25;
    localparam int OTP_HI_LSB  = 10;
    localparam int SECTOR_LSB  = 19;
    localparam int SECTOR_AW   = 8;
    localparam int CFG_W       = 16;

    // fill values
    localparam logic [7:0]  BYTE_UNDEF  = 8'hFF;
    localparam logic [7:0]  BYTE_ERASED = 8'hFF;

    // status flags seen by the host
    typedef struct packed {
        logic write_in_progress_flag;   // self-timed operation running
        logic write_enable_latch;   // write enable latch
        logic p_err; // program error
    } status_t;

    // self-timed operation in flight
    typedef enum logic [2:0] {
        OP_IDLE,
        OP_OTP,
        OP_CFG,
        OP_VOL,
        OP_PPROG,
        OP_PERASE
    } busy_op_t;

endpackage

/* design/bit_sync.sv */
// two-stage synchroniser for a group of asynchronous levels
// assumes inputs may change at any time relative to clk_in
`timescale 1ns/1ps

module bit_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clk_in,
    input  wire logic         rst_n_in,
    // async levels in, synced levels out
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] q_out
);

    typedef struct packed {
        logic [W-1:0] meta;   // first stage, read only by second
        logic [W-1:0] stable; // second stage
    } sync_t;

    sync_t s;
    sync_t next_s;

    // shift one stage per clock
    always_comb begin
        next_s.meta   = d_in;
        next_s.stable = s.meta;
    end

    // register with constant reset
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign q_out = s.stable;

endmodule

/* design/prot_cmd.sv */
// otp array and sector protection command engine of a serial flash
// assumes sck, cs_n and si come from an spi host in mode 0 or 3
// and that sck runs well below a quarter of clk_in
`timescale 1ns/1ps

module prot_cmd
    import prot_cmd_pkg::*;
#(
    parameter int          OTP_BUF_BYTES    = 16,
    parameter int          OTP_REGION_BYTES = 64,
    parameter int          PROG_CYCLES      = 200,
    parameter int          ERASE_CYCLES     = 2000,
    parameter logic [15:0] CFG_RESET        = 16'hFFFF,
    parameter logic [7:0]  VOL_PROT_RESET   = 8'h00
) (
    // clock and reset
    input  wire logic                    clk_in,
    input  wire logic                    rst_n_in,
    // spi pins
    input  wire logic                    sck_in,
    input  wire logic                    cs_n_in,
    input  wire logic                    si_in,
    output logic                         so_out,
    output logic                         so_oe_n_out,
    // control and status
    input  wire logic [OTP_BYTES/OTP_REGION_BYTES-1:0] otp_region_lock_in,
    input  wire logic                    p_err_clear_in,
    output status_t                      status_out,
    output logic      [CFG_W-1:0]        prot_cfg_out,
    output logic                         erase_suspend_req_out
);

    localparam int NREG   = OTP_BYTES / OTP_REGION_BYTES;
    localparam int REG_LSB = $clog2(OTP_REGION_BYTES);
    localparam int BUF_AW = $clog2(OTP_BUF_BYTES);
    localparam int NSECT  = 1 << SECTOR_AW;

    ////////////////////////////////////////////////////////////////////
    // elaboration checks
    generate
        if (PROG_CYCLES < OTP_BUF_BYTES || ERASE_CYCLES < 2 ||
            ERASE_CYCLES > 65535 || PROG_CYCLES > 65535 ||
            (1 << BUF_AW) != OTP_BUF_BYTES ||
            (1 << REG_LSB) != OTP_REGION_BYTES) begin : g_bad
            $error("prot_cmd: unsupported parameter values");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // state
    typedef struct packed {
        busy_op_t           op;       // running self-timed operation
        logic [15:0]        cnt;      // cycles into the operation
        logic [6:0]         tot;      // rising edges in frame, saturating
        logic [2:0]         bitpos;   // bit within current byte
        logic [7:0]         sh;       // input shifter
        logic [7:0]         opcode;   // latched opcode
        logic [31:0]        addr;     // latched address
        logic [15:0]        cfg_data; // config program data
        logic [7:0]         byte_in;  // volatile write data
        logic [BUF_AW:0]    nbytes;   // otp bytes buffered
        logic [7:0]         out_sh;   // output shifter
        logic [2:0]         out_cnt;  // bit within output byte
        logic               out_sel;  // config byte select
        logic [OTP_AW:0]    rd_ptr;   // otp read pointer
        logic               so;       // serial out level
        logic               so_oe_n;  // serial out enable, low drives
        logic               sck_q;    // previous synced sck
        logic               cs_q;     // previous synced cs_n
        logic [CFG_W-1:0]   cfg;      // protection config register
        status_t            st;       // status flags
        logic               susp;     // erase suspend pulse
    } state_t;

    state_t s;
    state_t next_s;

    // memories
    logic [7:0]       otp_mem [OTP_BYTES];
    logic [7:0]       vol_mem [NSECT];
    logic [NSECT-1:0] pers;
    logic [7:0]       otp_buf [OTP_BUF_BYTES];

    // memory write strobes from the combinational block
    logic              buf_we;
    logic [BUF_AW-1:0] buf_wa;
    logic              otp_we;
    logic [OTP_AW-1:0] otp_wa;
    logic [7:0]        otp_wd;
    logic              vol_we;
    logic              pers_clr_one;
    logic              pers_clr_all;
    logic              pers_set_all;

    // synced pins
    logic sck_s;
    logic cs_s;
    logic si_s;
    logic sel_s;  // synced select, high inside a frame

    // synchroniser clears to deselected, so no false frame edge
    assign cs_s = ~sel_s;

    bit_sync #(
        .W (3)
    ) u_sync (
        .clk_in   (clk_in),
        .rst_n_in (rst_n_in),
        .d_in     ({sck_in, ~cs_n_in, si_in}),
        .q_out    ({sck_s, sel_s, si_s})
    );

    ////////////////////////////////////////////////////////////////////
    // next-state logic
    always_comb begin
        logic              rise;
        logic              fall;
        logic [6:0]        tot_n;
        logic [7:0]        newb;
        logic [31:0]       addr_n;
        logic              out_act;
        logic [7:0]        src;
        logic              ok;
        logic [15:0]       last;
        logic [OTP_AW-1:0] ta;
        logic [7:0]        bd;
        logic              err;
        rise    = 1'b0;
        fall    = 1'b0;
        tot_n   = '0;
        newb    = '0;
        addr_n  = '0;
        out_act = 1'b0;
        src     = '0;
        ok      = 1'b0;
        last    = '0;
        ta      = '0;
        bd      = '0;
        err     = 1'b0;
        next_s  = s;
        buf_we  = 1'b0;
        buf_wa  = '0;
        otp_we  = 1'b0;
        otp_wa  = '0;
        otp_wd  = '0;
        vol_we  = 1'b0;
        pers_clr_one = 1'b0;
        pers_clr_all = 1'b0;
        pers_set_all = 1'b0;
        next_s.susp  = 1'b0;
        next_s.sck_q = sck_s;
        next_s.cs_q  = cs_s;
        rise = ~s.sck_q & sck_s & ~cs_s;
        fall = s.sck_q & ~sck_s & ~cs_s;
        ok   = (s.op == OP_IDLE) & s.st.write_enable_latch;

        // cs falls: new frame
        if (!cs_s && s.cs_q) begin
            next_s.tot     = '0;
            next_s.bitpos  = '0;
            next_s.out_cnt = '0;
            next_s.out_sel = 1'b0;
            if (s.op == OP_IDLE) begin
                next_s.nbytes = '0;
            end
        end

        // rising sck: shift in
        if (rise) begin
            newb          = {s.sh[6:0], si_s};
            tot_n         = (s.tot == BITS_SAT) ? s.tot : s.tot + 7'h01;
            addr_n        = {s.addr[30:0], si_s};
            next_s.sh     = newb;
            next_s.tot    = tot_n;
            next_s.bitpos = s.bitpos + 3'h1;
            if (tot_n == BITS_OPCODE) begin
                next_s.opcode = newb;
            end else if (tot_n <= BITS_ADDR) begin
                next_s.addr = addr_n;
            end
            // otp read pointer from the low address bits
            if (tot_n == BITS_ADDR) begin
                next_s.rd_ptr = {1'b0, addr_n[OTP_AW-1:0]};
            end
            // data byte complete
            if (tot_n > BITS_OPCODE && s.bitpos == 3'h7) begin
                case (s.opcode)
                    OP_CFG_PROGRAM: begin
                        // low byte first
                        if (tot_n <= BITS_CFG_DATA) begin
                            next_s.cfg_data = {newb, s.cfg_data[15:8]};
                        end
                    end
                    OP_VOL_WRITE: begin
                        if (tot_n == BITS_DUMMY) begin
                            next_s.byte_in = newb;
                        end
                    end
                    OP_OTP_WRITE: begin
                        // bytes past the buffer are dropped
                        // no buffer writes while a program runs
                        if (tot_n > BITS_ADDR && s.op == OP_IDLE &&
                            s.nbytes < OTP_BUF_BYTES[BUF_AW:0]) begin
                            buf_we        = 1'b1;
                            buf_wa        = s.nbytes[BUF_AW-1:0];
                            next_s.nbytes = s.nbytes + 1'b1;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end

        // falling sck: shift out read data
        case (s.opcode)
            OP_CFG_READ:  out_act = s.tot >= BITS_OPCODE;
            OP_VOL_READ:  out_act = s.tot >= BITS_ADDR;
            OP_PERS_READ: out_act = s.tot >= BITS_ADDR;
            OP_OTP_READ:  out_act = s.tot >= BITS_DUMMY;
            default:      out_act = 1'b0;
        endcase
        if (fall && out_act) begin
            next_s.so_oe_n = 1'b0;
            next_s.out_cnt = s.out_cnt + 3'h1;
            if (s.out_cnt == 3'h0) begin
                case (s.opcode)
                    OP_CFG_READ: begin
                        // alternate low/high byte
                        src = s.out_sel ? s.cfg[15:8] : s.cfg[7:0];
                        next_s.out_sel = ~s.out_sel;
                    end
                    OP_VOL_READ: begin
                        // same sector every byte
                        src = vol_mem[s.addr[SECTOR_LSB +: SECTOR_AW]];
                    end
                    OP_PERS_READ: begin
                        src = {8{pers[s.addr[SECTOR_LSB +: SECTOR_AW]]}};
                    end
                    default: begin
                        // stop at the top, no wrap
                        if (s.rd_ptr[OTP_AW]) begin
                            src = BYTE_UNDEF;
                        end else begin
                            src           = otp_mem[s.rd_ptr[OTP_AW-1:0]];
                            next_s.rd_ptr = s.rd_ptr + 1'b1;
                        end
                    end
                endcase
                next_s.so     = src[7];
                next_s.out_sh = {src[6:0], 1'b0};
            end else begin
                next_s.so     = s.out_sh[7];
                next_s.out_sh = {s.out_sh[6:0], 1'b0};
            end
        end

        // cs rises: decide whether a command runs
        if (cs_s && !s.cs_q) begin
            next_s.so_oe_n = 1'b1;
            case (s.opcode)
                OP_WRITE_ENABLE: begin
                    if (s.tot == BITS_OPCODE && s.op == OP_IDLE) begin
                        next_s.st.write_enable_latch = 1'b1;
                    end
                end
                OP_ERASE_SUSPEND: begin
                    if (s.tot == BITS_OPCODE && s.op != OP_PERASE) begin
                        next_s.susp = 1'b1;
                    end
                end
                OP_CFG_PROGRAM: begin
                    if (ok && s.tot == BITS_CFG_DATA) begin
                        next_s.op  = OP_CFG;
                        next_s.cnt = '0;
                    end
                end
                OP_VOL_WRITE: begin
                    if (ok && s.tot == BITS_DUMMY) begin
                        next_s.op  = OP_VOL;
                        next_s.cnt = '0;
                    end
                end
                OP_PERS_PROGRAM: begin
                    if (ok && s.tot == BITS_ADDR) begin
                        next_s.op  = OP_PPROG;
                        next_s.cnt = '0;
                    end
                end
                OP_PERS_ERASE: begin
                    if (ok && s.tot == BITS_OPCODE) begin
                        next_s.op  = OP_PERASE;
                        next_s.cnt = '0;
                    end
                end
                OP_OTP_WRITE: begin
                    // page-program framing, high address bits zero
                    if (ok && s.tot > BITS_ADDR && s.bitpos == 3'h0 &&
                        s.addr[OTP_HI_MSB:OTP_HI_LSB] == '0) begin
                        next_s.op  = OP_OTP;
                        next_s.cnt = '0;
                    end
                end
                default: begin
                end
            endcase
        end

        // self-timed operations
        last = (s.op == OP_PERASE) ? 16'(ERASE_CYCLES - 1)
                                   : 16'(PROG_CYCLES - 1);
        case (s.op)
            OP_IDLE: begin
            end
            OP_OTP: begin
                // one buffered byte per cycle, wrapping in the page
                if (s.cnt < 16'(s.nbytes)) begin
                    ta = {s.addr[OTP_AW-1:BUF_AW],
                          s.addr[BUF_AW-1:0] + s.cnt[BUF_AW-1:0]};
                    bd = otp_buf[s.cnt[BUF_AW-1:0]];
                    if (otp_region_lock_in[ta[OTP_AW-1:REG_LSB]]) begin
                        err = (bd != BYTE_ERASED);
                    end else begin
                        otp_we = 1'b1;
                        otp_wa = ta;
                        otp_wd = otp_mem[ta] & bd;
                    end
                end
            end
            OP_CFG: begin
                if (s.cnt == '0) begin
                    next_s.cfg = s.cfg & s.cfg_data;
                end
            end
            OP_VOL: begin
                vol_we = (s.cnt == '0);
            end
            OP_PPROG: begin
                pers_clr_one = (s.cnt == '0);
            end
            OP_PERASE: begin
                // preprogram first, erase at the end
                pers_clr_all = (s.cnt == '0);
                pers_set_all = (s.cnt == last);
            end
            default: begin
                next_s.op = OP_IDLE;
            end
        endcase
        if (s.op != OP_IDLE) begin
            next_s.cnt = s.cnt + 16'h0001;
            if (s.cnt == last) begin
                next_s.op     = OP_IDLE;
                next_s.st.write_enable_latch = 1'b0;
            end
        end
        next_s.st.write_in_progress_flag = (next_s.op != OP_IDLE);

        // error flag: set wins over clear
        if (err) begin
            next_s.st.p_err = 1'b1;
        end else if (p_err_clear_in) begin
            next_s.st.p_err = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s         <= '0;
            s.op      <= OP_IDLE;
            s.cfg     <= CFG_RESET;
            s.so_oe_n <= 1'b1;
            s.sck_q   <= 1'b0;
            s.cs_q    <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // memories
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            for (int i = 0; i < OTP_BYTES; i++) begin
                otp_mem[i] <= BYTE_ERASED;
            end
            for (int i = 0; i < NSECT; i++) begin
                vol_mem[i] <= VOL_PROT_RESET;
            end
            pers <= '1;
        end else begin
            if (otp_we) begin
                otp_mem[otp_wa] <= otp_wd;
            end
            if (vol_we) begin
                vol_mem[s.addr[SECTOR_LSB +: SECTOR_AW]] <= s.byte_in;
            end
            if (pers_set_all) begin
                pers <= '1;
            end else if (pers_clr_all) begin
                pers <= '0;
            end else if (pers_clr_one) begin
                pers[s.addr[SECTOR_LSB +: SECTOR_AW]] <= 1'b0;
            end
        end
    end

    // otp page buffer, contents undefined until written
    always_ff @(posedge clk_in) begin
        if (buf_we) begin
            otp_buf[buf_wa] <= {s.sh[6:0], si_s};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs
    assign so_out                = s.so;
    assign so_oe_n_out           = s.so_oe_n;
    assign status_out            = s.st;
    assign prot_cfg_out          = s.cfg;
    assign erase_suspend_req_out = s.susp;

endmodule

/* bench/prot_cmd_assertions.sv */
// port checks for the otp and sector protection command engine
// assumes binding onto prot_cmd, status flags active high
`timescale 1ns/1ps

module prot_cmd_assertions
    import prot_cmd_pkg::*;
(
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    // watched ports
    input  wire logic        cs_n_in,
    input  wire logic        so_oe_n_out,
    input  wire logic        p_err_clear_in,
    input  wire status_t     status_out,
    input  wire logic [15:0] prot_cfg_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    ////////////////
    // latch only rises after the frame is closed
    property p_wel_rise; $rose(status_out.write_enable_latch) |-> cs_n_in; endproperty
    a_wel_rise: assert property (p_wel_rise) else
        $error("latch rose inside a frame");
    // no self-timed work without the latch
    property p_wip_wel; $rose(status_out.write_in_progress_flag) |-> status_out.write_enable_latch; endproperty
    a_wip_wel: assert property (p_wip_wel) else
        $error("busy began with latch clear");
    // latch drops together with busy
    property p_end;
        $fell(status_out.write_in_progress_flag) |-> $fell(status_out.write_enable_latch);
    endproperty
    a_end: assert property (p_end) else
        $error("latch not cleared at end of busy");
    // busy lasts a while once started
    property p_busy; $rose(status_out.write_in_progress_flag) |=> status_out.write_in_progress_flag [*8]; endproperty
    a_busy: assert property (p_busy) else
        $error("busy too short");
    // config changes only during a program
    property p_cfg; $changed(prot_cfg_out) |-> status_out.write_in_progress_flag; endproperty
    a_cfg: assert property (p_cfg) else
        $error("config changed while idle");
    // output driven only inside or just after a frame
    property p_oe; !so_oe_n_out |-> !$past(cs_n_in, 6); endproperty
    a_oe: assert property (p_oe) else
        $error("output driven outside a frame");
    // error flag set only by a running program
    property p_err; $rose(status_out.p_err) |-> status_out.write_in_progress_flag; endproperty
    a_err: assert property (p_err) else
        $error("error flag set while idle");
    // error flag leaves only on a clear pulse
    property p_clr;
        $fell(status_out.p_err) |-> $past(p_err_clear_in);
    endproperty
    a_clr: assert property (p_clr) else
        $error("error flag dropped without clear");
endmodule

/* bench/spi_host.sv */
// spi host model, mode 0, sck idles low between frames
// assumes clk_in is the block clock; half sck period is 4 clocks
`timescale 1ns/1ps

module spi_host (
    // pacing clock
    input  wire logic clk_in,
    // spi pins
    output logic      sck_out,
    output logic      cs_n_out,
    output logic      si_out,
    input  wire logic so_in
);
    initial begin
        sck_out = 1'b0;
        cs_n_out = 1'b1;
        si_out = 1'b0;
    end
    ////////////////
    // half sck period, 100 ns, far under the read limit
    task automatic half();
        repeat (4) @(posedge clk_in);
        #2;
    endtask
    // n bits out msb first, then nrd bits
    task automatic frame(input logic [63:0] tx, input int n,
                         input int nrd, output logic [31:0] rx);
        rx = '0;
        cs_n_out = 1'b0;
        half();
        for (int i = n - 1; i >= 0; i--) begin
            si_out = tx[i];
            half();
            sck_out = 1'b1;
            half();
            sck_out = 1'b0;
        end
        for (int i = 0; i < nrd; i++) begin
            si_out = ~si_out; // line unused, keep it moving
            half();
            rx = {rx[30:0], so_in};
            sck_out = 1'b1;
            half();
            sck_out = 1'b0;
        end
        half();
        cs_n_out = 1'b1; // half sck period after last bit
        si_out = ~si_out; // released line
        repeat (2) half();
    endtask
endmodule

/* bench/tb.sv */
// self-checking bench for the protection command engine
// assumes spi_host drives the pins and the checker is bound below
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
    tests_run++; \
    if ((g) !== (e)) begin \
        $display("CHECK FAILED %s exp %h got %h", nm, e, g); \
        num_errors++; \
    end \
end

module tb
    import prot_cmd_pkg::*;
;
    logic        clk_in = 1'b0;
    logic        rst_n_in = 1'b0;
    logic        sck, cs_n, si, so, so_oe_n, susp;
    logic [31:0] lock = '0;
    logic        clr = 1'b0;
    status_t     st;
    logic [15:0] cfg;
    int          num_errors = 0;
    int          tests_run = 0;
    int          cycles = 0;
    int          sus = 0;
    logic [31:0] rx;
    logic [15:0] r;
    logic [7:0]  s, d, d1, d2;
    ////////////////
    prot_cmd #(.PROG_CYCLES(20), .ERASE_CYCLES(400)) prot_cmd_i (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .sck_in(sck), .cs_n_in(cs_n),
        .si_in(si), .so_out(so), .so_oe_n_out(so_oe_n),
        .otp_region_lock_in(lock), .p_err_clear_in(clr), .status_out(st),
        .prot_cfg_out(cfg), .erase_suspend_req_out(susp));
    spi_host spi_host_i (.clk_in(clk_in), .sck_out(sck), .cs_n_out(cs_n),
        .si_out(si), .so_in(so));
    always #12.5 clk_in = ~clk_in;
    // suspend pulse count and hang guard
    always @(posedge clk_in) begin
        cycles++;
        if (susp === 1'b1) sus++;
        if (cycles == 40000) begin
            num_errors++;
            final_report();
        end
    end
    task automatic final_report();
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic cmd(input logic [63:0] tx, input int n, input int nrd = 0);
        spi_host_i.frame(tx, n, nrd, rx);
    endtask
    // write enable, command, then wait out the busy time
    task automatic wr(input logic [63:0] tx, input int n);
        cmd(OP_WRITE_ENABLE, 8);
        cmd(tx, n);
        for (int i = 0; i < 3000 && st.write_in_progress_flag === 1'b1; i++) begin
            @(posedge clk_in);
            #2;
        end
        `CHK("busy ends", 1'b0, st.write_in_progress_flag)
    endtask
    initial begin
        void'($urandom(67));
        r = 16'($urandom);
        s = 8'($urandom);
        d = 8'($urandom);
        d1 = 8'($urandom);
        d2 = 8'($urandom);
        repeat (20) @(posedge clk_in);
        #2;
        rst_n_in = 1'b1;
        repeat (4) @(posedge clk_in);
        #2;
        `CHK("cfg reset", 16'hFFFF, cfg)
        cmd(OP_PERS_ERASE, 8);
        `CHK("erase no latch", 1'b0, st.write_in_progress_flag)
        cmd(OP_WRITE_ENABLE, 8);
        `CHK("latch", 1'b1, st.write_enable_latch)
        cmd({OP_CFG_PROGRAM, 15'h0000}, 23);
        `CHK("short cfg", 1'b0, st.write_in_progress_flag)
        wr({OP_CFG_PROGRAM, r[7:0], r[15:8]}, 24);
        `CHK("cfg prog", r, cfg)
        `CHK("latch after", 1'b0, st.write_enable_latch)
        cmd(OP_CFG_READ, 8, 32);
        `CHK("cfg read", {2{r[7:0], r[15:8]}}, rx)
        `CHK("so released", 1'b1, so_oe_n)
        wr({OP_VOL_WRITE, 5'h00, s, 19'h0_0000, d}, 48);
        cmd({OP_VOL_READ, 5'h00, s, 19'h0_0000}, 40, 16);
        `CHK("vol read", {d, d}, rx)
        wr({OP_PERS_PROGRAM, 5'h00, s, 19'h0_0000}, 40);
        cmd({OP_PERS_READ, 5'h00, s, 19'h0_0000}, 40, 16);
        `CHK("pers prog", 16'h0000, rx)
        cmd({OP_PERS_READ, 5'h00, ~s, 19'h0_0000}, 40, 8);
        `CHK("pers other", 8'hFF, rx)
        cmd(OP_ERASE_SUSPEND, 8);
        `CHK("suspend idle", 1, sus)
        cmd(OP_WRITE_ENABLE, 8);
        cmd(OP_PERS_ERASE, 8);
        `CHK("erase busy", 1'b1, st.write_in_progress_flag)
        cmd(OP_ERASE_SUSPEND, 8);
        `CHK("suspend refused", 1, sus)
        wr(OP_WRITE_ENABLE, 8);
        cmd({OP_PERS_READ, 5'h00, s, 19'h0_0000}, 40, 8);
        `CHK("pers erased", 8'hFF, rx)
        lock = 32'h0000_0002;
        wr({OP_OTP_WRITE, 32'h0000_0040, 8'hF0}, 48);
        `CHK("otp locked", 1'b1, st.p_err)
        clr = 1'b1;
        @(posedge clk_in);
        #2;
        clr = 1'b0;
        wr({OP_OTP_WRITE, 32'h0000_0040, 8'hFF}, 48);
        `CHK("otp ones", 1'b0, st.p_err)
        wr({OP_OTP_WRITE, 32'h0000_0010, d1}, 48);
        wr({OP_OTP_WRITE, 32'h0000_0010, d2}, 48);
        cmd({OP_OTP_READ, 32'h0000_0010, 8'h00}, 48, 8);
        `CHK("otp and", d1 & d2, rx)
        wr({OP_OTP_WRITE, 32'h0000_0410, 8'h00}, 48);
        cmd({OP_OTP_READ, 32'h0000_0410, 8'h00}, 48, 8);
        `CHK("otp high addr", 8'hFF, rx)
        wr({OP_OTP_WRITE, 32'h0000_0000, 1'b0, d[6:0]}, 48);
        cmd({OP_OTP_READ, 32'h0000_07FF, 8'h00}, 48, 16);
        `CHK("otp no wrap", 16'hFFFF, rx)
        final_report();
    end
endmodule

bind prot_cmd prot_cmd_assertions prot_cmd_assertions_i (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .cs_n_in(cs_n_in),
    .so_oe_n_out(so_oe_n_out), .p_err_clear_in(p_err_clear_in),
    .status_out(status_out), .prot_cfg_out(prot_cfg_out));
